/* File: inc/hbcsr_pkg.sv */
// Constants and types for the host bus configuration and status registers
package hbcsr_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_BUS_ERR   = 8'h06;
  localparam logic [7:0] OFS_CHIP_CFG  = 8'h08;
  localparam logic [7:0] OFS_PORT_SPC  = 8'hF4;
  localparam logic [7:0] OFS_PORT_CTL  = 8'hF6;
  localparam logic [7:0] OFS_PORT_STS  = 8'hF8;

  // ==========================================================================
  // Reset values and write masks
  localparam logic [15:0] RST_PORT_SPC = 16'h0000;
  localparam logic [15:0] RST_PORT_CTL = 16'h00FF;
  localparam logic [15:0] RST_PORT_STS = 16'h8080;
  localparam logic [15:0] WMSK_PORT_SPC = 16'hFFFF;
  localparam logic [15:0] WMSK_PORT_CTL = 16'hFFFF;
  localparam logic [15:0] WMSK_PORT_STS = 16'h0000;

  // ==========================================================================
  // Field positions
  localparam int ERR_FLAG_BIT   = 15;
  localparam int ERR_VAL_LSB    = 11;
  localparam int CFG_ENDIAN_BIT = 10;
  localparam int CFG_ROM_BIT    = 9;
  localparam int CFG_W8_BIT     = 7;
  localparam int CFG_W16_BIT    = 6;
  localparam int CFG_W32_BIT    = 5;
  localparam int CFG_PKG_BIT    = 3;

  // ==========================================================================
  // Strap bundle indices and settle count
  localparam int STRAP_N       = 5;
  localparam int STRAP_ENDIAN  = 0;
  localparam int STRAP_ROM     = 1;
  localparam int STRAP_DATA_IN = 2;
  localparam int STRAP_BUS32   = 3;
  localparam int STRAP_PKG128  = 4;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // ==========================================================================
  // Bus width modes
  typedef enum logic [1:0] {
    HBCSR_W8,
    HBCSR_W16,
    HBCSR_W32
  } hbcsr_width_t;

endpackage

/* File: inc/hbcsr_reg_if.sv */
// Carrier between the decoder and one 16-bit register store
`timescale 1ns/1ps
interface hbcsr_reg_if;
  logic [1:0]  wr_byte;
  logic [15:0] wdata;
  logic [15:0] q;

  modport ctrl  (output wr_byte, output wdata, input q);
  modport store (input wr_byte, input wdata, output q);
endinterface

/* File: rtl/hbcsr_reg16.sv */
// Byte-writable 16-bit register with reset value and write mask
`timescale 1ns/1ps
module hbcsr_reg16 #(
  parameter logic [15:0] RESET_VAL = 16'h0000,
  parameter logic [15:0] WR_MASK   = 16'hFFFF
) (
  // Clock and reset
  input  wire logic      i_core_clk,
  input  wire logic      i_rst_n,
  // Register access
  hbcsr_reg_if.store     bus
);

  typedef struct packed {
    logic [15:0] val;
  } hbcsr_reg_st_t;

  hbcsr_reg_st_t st;
  hbcsr_reg_st_t next_st;

  always_comb begin
    next_st = st;
    for (int b = 0; b < 2; b++) begin
      if (bus.wr_byte[b]) begin
        // Masked bits keep their state on writes
        next_st.val[8*b +: 8] = (bus.wdata[8*b +: 8] & WR_MASK[8*b +: 8]) |
                                (st.val[8*b +: 8] & ~WR_MASK[8*b +: 8]);
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st.val <= RESET_VAL;
    end else begin
      st <= next_st;
    end
  end

  assign bus.q = st.val;

endmodule

/* File: rtl/hbcsr_strap.sv */
// Strap pin synchroniser and capture after reset release
`timescale 1ns/1ps
module hbcsr_strap (
  // Clock and reset
  input  wire logic                         i_core_clk,
  input  wire logic                         i_rst_n,
  // Strap pins
  input  wire logic [hbcsr_pkg::STRAP_N-1:0] i_pins,
  // Captured levels
  output logic [hbcsr_pkg::STRAP_N-1:0]      o_latched,
  output logic                               o_valid
);

  typedef struct packed {
    logic [hbcsr_pkg::STRAP_N-1:0] sync1;
    logic [hbcsr_pkg::STRAP_N-1:0] sync2;
    logic [1:0]                    cnt;
    logic [hbcsr_pkg::STRAP_N-1:0] latched;
    logic                          valid;
  } hbcsr_strap_st_t;

  hbcsr_strap_st_t st;
  hbcsr_strap_st_t next_st;

  always_comb begin
    next_st       = st;
    next_st.sync1 = i_pins;
    next_st.sync2 = st.sync1;
    if (!st.valid) begin
      // Wait until the second stage holds a post-reset sample
      if (st.cnt == hbcsr_pkg::STRAP_SETTLE) begin
        next_st.latched = st.sync2;
        next_st.valid   = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_latched = st.latched;
  assign o_valid   = st.valid;

endmodule

/* File: rtl/hbcsr_top.sv */
// Host bus configuration and status register bank
`timescale 1ns/1ps
module hbcsr_top (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  // Strap and bonding pins
  input  wire logic        i_serial_rom_clock_pin,
  input  wire logic        i_serial_rom_present_pin,
  input  wire logic        i_serial_rom_data_in_pin,
  input  wire logic        i_bond_bus32,
  input  wire logic        i_bond_pkg128,
  // Bus width from the serial ROM loader
  input  wire logic        i_rom_width_valid,
  input  wire logic        i_rom_width8,
  input  wire logic        i_rom_width16,
  // Host bus
  input  wire logic [7:0]  i_host_addr,
  input  wire logic [3:0]  i_host_be,
  input  wire logic        i_host_rd,
  input  wire logic        i_host_wr,
  input  wire logic [31:0] i_host_wdata,
  output logic [31:0]      o_host_rdata,
  output logic             o_host_ack,
  // Configuration status
  output logic             o_cfg_valid,
  output logic             o_little_endian
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic        err_flag;
    logic [3:0]  err_val;
    logic        rom_w8;
    logic        rom_w16;
    logic [31:0] rdata;
    logic        ack;
  } hbcsr_top_st_t;

  hbcsr_top_st_t st;
  hbcsr_top_st_t next_st;

  logic [hbcsr_pkg::STRAP_N-1:0] strap;
  logic                          strap_valid;
  logic [15:0]                   err_word;
  logic [15:0]                   cfg_word;
  logic                          cfg_w8;
  logic                          cfg_w16;
  hbcsr_pkg::hbcsr_width_t       width;
  logic                          access;
  logic                          be_legal;
  logic [7:0]                    lane_addr [4];
  logic [3:0]                    lane_on;
  logic [1:0]                    wr_spc;
  logic [1:0]                    wr_ctl;
  logic [1:0]                    wr_sts;
  logic [15:0]                   wd_spc;
  logic [15:0]                   wd_ctl;
  logic [15:0]                   wd_sts;
  logic                          err_clear;

  hbcsr_reg_if if_spc ();
  hbcsr_reg_if if_ctl ();
  hbcsr_reg_if if_sts ();

  // ==========================================================================
  // Strap capture
  hbcsr_strap u_strap (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_pins     ({i_bond_pkg128, i_bond_bus32, i_serial_rom_data_in_pin,
                  i_serial_rom_present_pin, i_serial_rom_clock_pin}),
    .o_latched  (strap),
    .o_valid    (strap_valid)
  );

  // ==========================================================================
  // Configuration word
  always_comb begin
    if (strap[hbcsr_pkg::STRAP_ROM]) begin
      cfg_w8  = st.rom_w8;
      cfg_w16 = st.rom_w16;
    end else begin
      // Data-in strap high selects 8-bit, low selects 16-bit
      cfg_w8  = strap[hbcsr_pkg::STRAP_DATA_IN];
      cfg_w16 = ~strap[hbcsr_pkg::STRAP_DATA_IN];
    end
    cfg_word = 16'h0000;
    cfg_word[hbcsr_pkg::CFG_ENDIAN_BIT] =
      strap[hbcsr_pkg::STRAP_ENDIAN];
    cfg_word[hbcsr_pkg::CFG_ROM_BIT] =
      strap[hbcsr_pkg::STRAP_ROM];
    cfg_word[hbcsr_pkg::CFG_W8_BIT]  = cfg_w8;
    cfg_word[hbcsr_pkg::CFG_W16_BIT] = cfg_w16;
    cfg_word[hbcsr_pkg::CFG_W32_BIT] =
      strap[hbcsr_pkg::STRAP_BUS32];
    cfg_word[hbcsr_pkg::CFG_PKG_BIT] =
      strap[hbcsr_pkg::STRAP_PKG128];

    err_word = 16'h0000;
    err_word[hbcsr_pkg::ERR_FLAG_BIT] = st.err_flag;
    err_word[hbcsr_pkg::ERR_VAL_LSB +: 4] = st.err_val;

    // 32-bit variant wins; otherwise the 8-bit bit picks the width
    if (strap[hbcsr_pkg::STRAP_BUS32]) begin
      width = hbcsr_pkg::HBCSR_W32;
    end else if (cfg_w8) begin
      width = hbcsr_pkg::HBCSR_W8;
    end else begin
      width = hbcsr_pkg::HBCSR_W16;
    end
  end

  // ==========================================================================
  // Lane decode per bus width
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      lane_addr[k] = i_host_addr;
    end
    lane_on  = 4'h0;
    be_legal = 1'b0;
    case (width)
      hbcsr_pkg::HBCSR_W32: begin
        for (int k = 0; k < 4; k++) begin
          lane_addr[k] = {i_host_addr[7:2], 2'(k)};
        end
        lane_on  = i_host_be;
        be_legal = (i_host_be == 4'h1) || (i_host_be == 4'h2) ||
                   (i_host_be == 4'h4) || (i_host_be == 4'h8) ||
                   (i_host_be == 4'h3) || (i_host_be == 4'hC) ||
                   (i_host_be == 4'hF);
      end
      hbcsr_pkg::HBCSR_W16: begin
        for (int k = 0; k < 2; k++) begin
          lane_addr[k] = {i_host_addr[7:1], 1'(k)};
        end
        lane_on  = {2'h0, i_host_be[1:0]};
        be_legal = (i_host_be[3:2] == 2'h0) && (i_host_be[1:0] != 2'h0);
      end
      hbcsr_pkg::HBCSR_W8: begin
        lane_on  = {3'h0, i_host_be[0]};
        be_legal = (i_host_be == 4'h1);
      end
      default: begin
        lane_on  = 4'h0;
        be_legal = 1'b0;
      end
    endcase
  end

  // Strap capture gates the bus: width is unknown before it
  assign access = strap_valid && (i_host_rd || i_host_wr);

  // ==========================================================================
  // Read byte mux
  function automatic logic [7:0] byte_at(input logic [7:0] a,
                                         input logic [15:0] ew,
                                         input logic [15:0] cw,
                                         input logic [15:0] sp,
                                         input logic [15:0] ct,
                                         input logic [15:0] ss);
    logic [15:0] w;
    case ({a[7:1], 1'b0})
      hbcsr_pkg::OFS_BUS_ERR:  w = ew;
      hbcsr_pkg::OFS_CHIP_CFG: w = cw;
      hbcsr_pkg::OFS_PORT_SPC: w = sp;
      hbcsr_pkg::OFS_PORT_CTL: w = ct;
      hbcsr_pkg::OFS_PORT_STS: w = ss;
      default:                 w = 16'h0000;
    endcase
    return a[0] ? w[15:8] : w[7:0];
  endfunction

  // ==========================================================================
  // Write byte decode
  always_comb begin
    wr_spc    = 2'h0;
    wr_ctl    = 2'h0;
    wr_sts    = 2'h0;
    wd_spc    = 16'h0000;
    wd_ctl    = 16'h0000;
    wd_sts    = 16'h0000;
    err_clear = 1'b0;
    if (access && i_host_wr && be_legal) begin
      for (int k = 0; k < 4; k++) begin
        if (lane_on[k]) begin
          for (int j = 0; j < 2; j++) begin
            if (lane_addr[k] == hbcsr_pkg::OFS_PORT_SPC + 8'(j)) begin
              wr_spc[j]         = 1'b1;
              wd_spc[8*j +: 8]  = i_host_wdata[8*k +: 8];
            end
            if (lane_addr[k] == hbcsr_pkg::OFS_PORT_CTL + 8'(j)) begin
              wr_ctl[j]         = 1'b1;
              wd_ctl[8*j +: 8]  = i_host_wdata[8*k +: 8];
            end
            if (lane_addr[k] == hbcsr_pkg::OFS_PORT_STS + 8'(j)) begin
              wr_sts[j]         = 1'b1;
              wd_sts[8*j +: 8]  = i_host_wdata[8*k +: 8];
            end
          end
          // Flag sits in bit 7 of the high byte at offset 0x07
          if ((lane_addr[k] == hbcsr_pkg::OFS_BUS_ERR + 8'h01) &&
              i_host_wdata[8*k + hbcsr_pkg::ERR_FLAG_BIT - 8]) begin
            err_clear = 1'b1;
          end
        end
      end
    end
  end

  assign if_spc.wr_byte = wr_spc;
  assign if_spc.wdata   = wd_spc;
  assign if_ctl.wr_byte = wr_ctl;
  assign if_ctl.wdata   = wd_ctl;
  assign if_sts.wr_byte = wr_sts;
  assign if_sts.wdata   = wd_sts;

  // ==========================================================================
  // Port register stores
  hbcsr_reg16 #(
    .RESET_VAL (hbcsr_pkg::RST_PORT_SPC),
    .WR_MASK   (hbcsr_pkg::WMSK_PORT_SPC)
  ) u_port_spc (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .bus        (if_spc.store)
  );

  hbcsr_reg16 #(
    .RESET_VAL (hbcsr_pkg::RST_PORT_CTL),
    .WR_MASK   (hbcsr_pkg::WMSK_PORT_CTL)
  ) u_port_ctl (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .bus        (if_ctl.store)
  );

  // Status is read-only from the host: mask blocks every write
  hbcsr_reg16 #(
    .RESET_VAL (hbcsr_pkg::RST_PORT_STS),
    .WR_MASK   (hbcsr_pkg::WMSK_PORT_STS)
  ) u_port_sts (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .bus        (if_sts.store)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    next_st     = st;
    next_st.ack = access;
    if (i_rom_width_valid) begin
      next_st.rom_w8  = i_rom_width8;
      next_st.rom_w16 = i_rom_width16;
    end
    if (access && i_host_rd) begin
      next_st.rdata = 32'h0000_0000;
      if (be_legal) begin
        for (int k = 0; k < 4; k++) begin
          if (lane_on[k]) begin
            next_st.rdata[8*k +: 8] = byte_at(lane_addr[k], err_word,
                                              cfg_word, if_spc.q,
                                              if_ctl.q, if_sts.q);
          end
        end
      end
    end
    if (err_clear) begin
      next_st.err_flag = 1'b0;
    end
    // A new error in the clearing cycle still sets the flag
    if (access && !be_legal) begin
      next_st.err_flag = 1'b1;
      next_st.err_val  = i_host_be;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign o_host_rdata    = st.rdata;
  assign o_host_ack      = st.ack;
  assign o_cfg_valid     = strap_valid;
  assign o_little_endian = strap[hbcsr_pkg::STRAP_ENDIAN];

endmodule

/* File: tb/hbcsr_top_chk.sv */
// Port-level assertions for the host register bank
`timescale 1ns/1ps
module hbcsr_top_chk (
  // Clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  // Straps
  input wire logic        i_serial_rom_clock_pin,
  input wire logic        i_bond_bus32,
  input wire logic        i_bond_pkg128,
  // Host bus
  input wire logic [7:0]  i_host_addr,
  input wire logic [3:0]  i_host_be,
  input wire logic        i_host_rd,
  input wire logic        i_host_wr,
  input wire logic [31:0] o_host_rdata,
  input wire logic        o_host_ack,
  input wire logic        o_cfg_valid,
  input wire logic        o_little_endian
);
  // ==========================================================================
  // Helpers
  logic bad32;
  logic rd_ok;
  assign bad32 = !(i_host_be inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8,
                                     4'h3, 4'hC, 4'hF});
  assign rd_ok = i_host_rd && o_cfg_valid && i_bond_bus32;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  // ==========================================================================
  // Properties
  ack_after_req_a: assert property (
    (i_host_rd || i_host_wr) && o_cfg_valid |=> o_host_ack)
    else $error("no ack after accepted request");
  ack_has_cause_a: assert property (o_host_ack |->
    $past(i_host_rd || i_host_wr) && $past(o_cfg_valid))
    else $error("ack without request");
  valid_rises_a: assert property (
    $rose(i_rst_n) |-> ##[2:6] o_cfg_valid)
    else $error("straps not captured in time");
  valid_holds_a: assert property (o_cfg_valid |=> o_cfg_valid)
    else $error("config valid dropped");
  endian_latched_a: assert property (o_cfg_valid |->
    o_little_endian == i_serial_rom_clock_pin)
    else $error("endian flag differs from strap");
  rdata_holds_a: assert property (!(i_host_rd && o_cfg_valid)
    |=> $stable(o_host_rdata)) else $error("read data moved");
  bad_read_zero_a: assert property (rd_ok && bad32
    |=> o_host_rdata == 32'h0) else $error("illegal read gave data");
  status_const_a: assert property (rd_ok && i_host_addr == 8'hF8
    && i_host_be == 4'h3 |=> o_host_rdata[15:0] == 16'h8080)
    else $error("port status not at reset value");
  cfg_bits_a: assert property (rd_ok
    && i_host_addr == 8'h08 && i_host_be == 4'h3 |=> o_host_rdata[5]
    && o_host_rdata[3] == i_bond_pkg128)
    else $error("variant or package bit wrong");
endmodule

/* File: tb/hbcsr_host_model.sv */
// Host processor model on the parallel register port
`timescale 1ns/1ps
module hbcsr_host_model (
  // Clock
  input  wire logic        i_core_clk,
  // Answer
  input  wire logic        i_ack,
  input  wire logic [31:0] i_rdata,
  // Request
  output logic [7:0]       o_addr,
  output logic [3:0]       o_be,
  output logic             o_rd,
  output logic             o_wr,
  output logic [31:0]      o_wdata
);
  initial begin
    o_addr = 8'h00;
    o_be = 4'h0;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 32'hA5A5_5A5A;
  end

  // One-cycle strobe at a falling edge; answer read one cycle on
  task automatic xfer(input logic rd, input logic [7:0] a,
                      input logic [3:0] b, input logic [31:0] d,
                      output logic ack, output logic [31:0] q);
    @(negedge i_core_clk);
    o_addr = a;
    o_be = b;
    o_rd = rd;
    o_wr = !rd;
    o_wdata = rd ? ~o_wdata : d;
    @(negedge i_core_clk);
    ack = i_ack;
    q = i_rdata;
    o_rd = 1'b0;
    o_wr = 1'b0;
    // Idle data is scrambled so stale values never look valid
    o_wdata = ~o_wdata;
    o_addr = ~o_addr;
  endtask

  // Reserved bits go back exactly as read
  task automatic write_back(input logic [7:0] a, input logic [3:0] b,
                            output logic ack, output logic [31:0] q);
    xfer(1'b1, a, b, 32'h0, ack, q);
    xfer(1'b0, a, b, q, ack, q);
  endtask
endmodule

/* File: tb/hbcsr_top_tb_top.sv */
// Self-checking bench for the host register bank
`timescale 1ns/1ps
module hbcsr_top_tb_top;
  logic        i_core_clk;
  logic        i_rst_n;
  logic        s_clk, s_rom, s_din, s_b32, s_p128;
  logic        rom_vld, rom_w8, rom_w16;
  logic [7:0]  addr;
  logic [3:0]  be;
  logic        rd_s, wr_s, ack, cfg_valid, little;
  logic [31:0] wdata, rdata, a_q;
  logic        a_ack;
  int          n_errors;
  int          n_compared;
  logic [3:0]  bad [8] = '{4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hD, 4'hE};

  hbcsr_top dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_serial_rom_clock_pin(s_clk), .i_serial_rom_present_pin(s_rom),
    .i_serial_rom_data_in_pin(s_din), .i_bond_bus32(s_b32),
    .i_bond_pkg128(s_p128), .i_rom_width_valid(rom_vld),
    .i_rom_width8(rom_w8), .i_rom_width16(rom_w16), .i_host_addr(addr),
    .i_host_be(be), .i_host_rd(rd_s), .i_host_wr(wr_s),
    .i_host_wdata(wdata), .o_host_rdata(rdata), .o_host_ack(ack),
    .o_cfg_valid(cfg_valid), .o_little_endian(little));

  hbcsr_host_model u_host (.i_core_clk(i_core_clk), .i_ack(ack),
    .i_rdata(rdata), .o_addr(addr), .o_be(be), .o_rd(rd_s),
    .o_wr(wr_s), .o_wdata(wdata));

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] b,
                    input logic [31:0] d);
    u_host.xfer(1'b0, a, b, d, a_ack, a_q);
    check("write ack", {31'h0, a_ack}, 32'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [3:0] b,
                    input logic [31:0] m, input logic [31:0] e);
    u_host.xfer(1'b1, a, b, 32'h0, a_ack, a_q);
    check("read ack", {31'h0, a_ack}, 32'h1);
    check("read data", a_q & m, e);
  endtask

  // Straps change only while reset is held
  task automatic do_reset(input logic [4:0] s, input logic early);
    int i;
    @(negedge i_core_clk);
    i_rst_n = 1'b0;
    {s_clk, s_rom, s_din, s_b32, s_p128} = s;
    repeat (10) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    if (early) begin
      u_host.xfer(1'b0, 8'hF6, 4'h3, 32'h1111, a_ack, a_q);
      check("early ack", {31'h0, a_ack}, 32'h0);
    end
    i = 0;
    while (cfg_valid !== 1'b1 && i < 10) begin
      @(negedge i_core_clk);
      i++;
    end
    check("config valid", {31'h0, cfg_valid}, 32'h1);
  endtask

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge i_core_clk);
    n_errors++;
    $display("watchdog expired");
    give_verdict;
  end

  initial begin
    i_rst_n = 1'b0;
    {s_clk, s_rom, s_din, s_b32, s_p128} = 5'h00;
    rom_vld = 1'b0;
    rom_w8 = 1'b0;
    rom_w16 = 1'b0;
    n_errors = 0;
    n_compared = 0;
    // ========================================================================
    // 32-bit variant
    do_reset(5'b10011, 1'b0);
    check("endian", {31'h0, little}, 32'h1);
    rd(8'h08, 4'h3, 32'h0628, 32'h0428);
    rd(8'hF4, 4'hF, 32'hFFFF_FFFF, 32'h00FF_0000);
    rd(8'hF8, 4'h3, 32'h0000_FFFF, 32'h0000_8080);
    rd(8'hF8, 4'h2, 32'h0000_FF00, 32'h0000_8000);
    wr(8'hF4, 4'hC, 32'h1234_0000);
    wr(8'hF4, 4'h1, 32'h0000_00A5);
    wr(8'hF8, 4'h3, 32'h0000_FFFF);
    wr(8'hF4, 4'h5, 32'hFFFF_FFFF);
    rd(8'hF4, 4'hF, 32'hFFFF_FFFF, 32'h1234_00A5);
    rd(8'hF8, 4'h3, 32'h0000_FFFF, 32'h0000_8080);
    rd(8'hF0, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test 32-bit access done");
    foreach (bad[k]) begin
      rd(8'h08, bad[k], 32'hFFFF_FFFF, 32'h0000_0000);
      rd(8'h04, 4'hC, 32'hF800_0000, {1'b1, bad[k], 27'h0});
    end
    wr(8'h04, 4'h8, 32'h0000_0000);
    rd(8'h04, 4'h8, 32'h8000_0000, 32'h8000_0000);
    u_host.write_back(8'h04, 4'hC, a_ack, a_q);
    rd(8'h04, 4'h8, 32'h8000_0000, 32'h0000_0000);
    $display("test bus error done");
    // ========================================================================
    // 8-bit from the data-in strap
    do_reset(5'b00100, 1'b0);
    check("endian", {31'h0, little}, 32'h0);
    rd(8'h08, 4'h1, 32'h00FF, 32'h0080);
    rd(8'h09, 4'h1, 32'h0000_00FF, 32'h0000_0000);
    rd(8'hF6, 4'h1, 32'h0000_00FF, 32'h0000_00FF);
    rd(8'hF9, 4'h1, 32'h0000_00FF, 32'h0000_0080);
    wr(8'hF7, 4'h1, 32'h0000_005A);
    rd(8'hF7, 4'h1, 32'h0000_00FF, 32'h0000_005A);
    rd(8'hF6, 4'h1, 32'h0000_00FF, 32'h0000_00FF);
    rd(8'h08, 4'h2, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(8'h07, 4'h1, 32'h0000_00FF, 32'h0000_0090);
    $display("test 8-bit done");
    // ========================================================================
    // 16-bit from the serial ROM, data-in strap overruled
    do_reset(5'b11101, 1'b1);
    @(negedge i_core_clk);
    rom_vld = 1'b1;
    rom_w16 = 1'b1;
    @(negedge i_core_clk);
    rom_vld = 1'b0;
    rd(8'h08, 4'h3, 32'hFFFF, 32'h0648);
    rd(8'hF6, 4'h3, 32'h0000_FFFF, 32'h0000_00FF);
    rd(8'h08, 4'h4, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(8'h06, 4'h3, 32'h0000_F800, 32'h0000_A000);
    // Loader now reports 8-bit: the bus follows the ROM, not the strap
    @(negedge i_core_clk);
    rom_vld = 1'b1;
    rom_w8 = 1'b1;
    rom_w16 = 1'b0;
    @(negedge i_core_clk);
    rom_vld = 1'b0;
    rd(8'h08, 4'h1, 32'h0000_00FF, 32'h0000_0088);
    $display("test 16-bit done");
    give_verdict;
  end
endmodule

bind hbcsr_top hbcsr_top_chk u_chk (.i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n), .i_serial_rom_clock_pin(i_serial_rom_clock_pin),
  .i_bond_bus32(i_bond_bus32), .i_bond_pkg128(i_bond_pkg128),
  .i_host_addr(i_host_addr), .i_host_be(i_host_be),
  .i_host_rd(i_host_rd), .i_host_wr(i_host_wr),
  .o_host_rdata(o_host_rdata), .o_host_ack(o_host_ack),
  .o_cfg_valid(o_cfg_valid), .o_little_endian(o_little_endian));
